// ### dispatch_pkg.sv
// Purpose: Shared constants and types for the handler dispatch block
// Assumes: 50 MHz core clock
// Notes: Entry offsets are 14-bit values inside the handler region
package dispatch_pkg;
    localparam int OFFSET_WIDTH = 14;
    localparam int PC_WIDTH = 34;
    localparam int FUNC_WIDTH = 8;
    localparam int MODE_WIDTH = 2;
    localparam logic [13:0] RESET_OFFSET = 14'h0000;
    localparam logic [13:0] MACHINE_CHECK_ENTRY_OFFSET = 14'h0020;
    localparam logic [13:0] ARITHMETIC_TRAP_ENTRY_OFFSET = 14'h0060;
    localparam logic [13:0] INTR_OFFSET = 14'h00e0;
    localparam logic [13:0] DFAULT_OFFSET = 14'h01e0;
    localparam logic [13:0] ITLB_OFFSET = 14'h03e0;
    localparam logic [13:0] IVIOL_OFFSET = 14'h07e0;
    localparam logic [13:0] DTLB_NATIVE_OFFSET = 14'h08e0;
    localparam logic [13:0] DTLB_HANDLER_OFFSET = 14'h09e0;
    localparam logic [13:0] MISALIGN_OFFSET = 14'h11e0;
    localparam logic [13:0] ILLEGAL_OFFSET = 14'h13e0;
    localparam logic [13:0] FPDIS_OFFSET = 14'h17e0;
    localparam logic [13:0] PRIV_TRAP_BASE = 14'h2000;
    localparam logic [13:0] USER_TRAP_BASE = 14'h3000;
    localparam int TRAP_SHIFT = 6;
    localparam logic [7:0] PRIV_RANGE_LO = 8'h00;
    localparam logic [7:0] PRIV_RANGE_HI = 8'h3f;
    localparam logic [7:0] USER_RANGE_LO = 8'h80;
    localparam logic [7:0] USER_RANGE_HI = 8'hbf;
    localparam logic [1:0] KERNEL_MODE = 2'h0;
    localparam logic [33:0] RETURN_STEP = 34'h000000004;
    localparam logic [33:0] BASE_RESET = 34'h000000000;
    localparam int BASE_LSB = 14;
    typedef enum logic [1:0] {
        FP_ROUND_CHOPPED,
        FP_ROUND_MINUS_INF,
        FP_ROUND_NORMAL,
        FP_ROUND_PLUS_INF
    } fp_round_t;
    typedef enum logic [1:0] {
        FP_TYPE_S,
        FP_TYPE_OTHER,
        FP_TYPE_T,
        FP_TYPE_Q
    } fp_type_t;
endpackage

// ### dstream_if.sv
// Purpose: Carries one data reference's error flags to the selector
// Assumes: All flags belong to the same reference
// Notes: Selector answers combinationally
`timescale 1ns/1ps
interface dstream_if;
    logic badVaddr;
    logic dtlbMiss;
    logic misalign;
    logic fault;
    logic handlerMode;
    logic hit;
    logic [13:0] offset;
    modport requester(output badVaddr, dtlbMiss, misalign, fault,
        handlerMode, input hit, offset);
    modport selector(input badVaddr, dtlbMiss, misalign, fault,
        handlerMode, output hit, offset);
endinterface

// ### dstream_error_select.sv
// Purpose: Picks one data-stream error entry per reference
// Assumes: Flags are valid together in one cycle
// Notes: Purely combinational
`timescale 1ns/1ps
module dstream_error_select
    import dispatch_pkg::*;
(
    dstream_if.selector ds
);
    // ==========================================
    // Entry choice
    always_comb begin
        ds.hit = 1'b1;
        ds.offset = DFAULT_OFFSET;
        if (ds.badVaddr) begin
            ds.offset = ds.misalign ? MISALIGN_OFFSET : DFAULT_OFFSET;
        end else if (ds.dtlbMiss) begin
            ds.offset = ds.handlerMode ? DTLB_HANDLER_OFFSET
                                       : DTLB_NATIVE_OFFSET;
        end else if (ds.misalign) begin
            ds.offset = MISALIGN_OFFSET;
        end else if (ds.fault) begin
            ds.offset = DFAULT_OFFSET;
        end else begin
            ds.hit = 1'b0;
        end
    end
endmodule

// ### privileged_handler_dispatch.sv
// Purpose: Redirects the core into privileged handler mode
// Assumes: Request inputs are synchronous to core_clk and held until drain
// Notes: One dispatch per drained pipeline; return via handlerReturn
//
// What this block does
// - Traps follow event sequence: drain, save, redirect
// - Trap saves instruction address plus four
// - Unsupported trap codes go to illegal entry
// - Privileged trap outside kernel mode is illegal
// - Highest priority pending entry wins
// - New PC: base high bits, offset low
// - Handler base clears to zero at reset
// - Reset, check, arithmetic, interrupt fixed offsets
// - Reserved opcodes, or privileged-only ones outside handler mode, go illegal
// - FP op with FP disabled traps
// - Bad IEEE rounding or datatype traps too
// - Privileged trap offset 2000 plus code shifted
// - Unprivileged trap offset 3000 plus code shifted
// - Each trap function owns 64-byte region
// - Bad address picks misalign or fault
// - Data TLB miss entry chosen by mode
// - Else misalign first, then fault entry
// - Reset enters handler mode until clean return
// - Return jumps, LSB gives mode flag
// - Handler mode: no ifetch mapping, no interrupts
`timescale 1ns/1ps
module privileged_handler_dispatch
    import dispatch_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic machineCheck,
    input wire logic arithTrap,
    input wire logic interruptReq,
    input wire logic badVaddrFlag,
    input wire logic dtlbMiss,
    input wire logic misalignFlag,
    input wire logic dataFault,
    input wire logic itlbMiss,
    input wire logic ifetchViolation,
    input wire logic softwareTrapInstr,
    input wire logic [7:0] trapFunction,
    input wire logic reservedOpcode,
    input wire logic handlerOnlyInstr,
    input wire logic fpOperation,
    input wire logic fpIeee,
    input wire logic [1:0] fpRound,
    input wire logic [1:0] fpDatatype,
    input wire logic fpEnableBit,
    input wire logic [1:0] currentModeField,
    input wire logic [33:0] faultPc,
    input wire logic pipeDrained,
    input wire logic handlerReturnInstr,
    input wire logic baseWrite,
    input wire logic [33:0] baseWriteData,
    input wire logic returnAddrWrite,
    input wire logic [33:0] returnAddrWriteData,
    output logic drainRequest,
    output logic fetchRedirect,
    output logic [33:0] newPc,
    output logic [13:0] entryOffset,
    output logic [33:0] exceptionReturnAddress,
    output logic [33:0] handlerBaseAddress,
    output logic privilegedHandlerMode,
    output logic interruptEnable,
    output logic imapEnable,
    output logic dmapEnable
);
    // ==========================================
    // Trap code decode
    function automatic logic inRange(input logic [7:0] code,
        input logic [7:0] lo, input logic [7:0] hi);
        inRange = (code >= lo) && (code <= hi);
    endfunction

    function automatic logic [13:0] trapOffset(input logic [13:0] base,
        input logic [7:0] code);
        trapOffset = base | (14'(code[5:0]) << TRAP_SHIFT);
    endfunction

    logic privTrap;
    logic userTrap;
    logic trapIllegal;
    logic fpDisabled;
    logic anyFpTrap;
    logic illegalHit;
    assign privTrap = inRange(trapFunction, PRIV_RANGE_LO, PRIV_RANGE_HI);
    assign userTrap = inRange(trapFunction, USER_RANGE_LO, USER_RANGE_HI);
    assign trapIllegal = softwareTrapInstr && (!(privTrap || userTrap)
        || (privTrap && currentModeField != KERNEL_MODE));
    assign illegalHit = trapIllegal || reservedOpcode
        || (handlerOnlyInstr && !privilegedHandlerMode);
    assign fpDisabled = fpOperation && !fpEnableBit;
    assign anyFpTrap = fpDisabled || (fpOperation && fpIeee
        && (fpRound == FP_ROUND_PLUS_INF || fpRound == FP_ROUND_MINUS_INF
        || fpDatatype == FP_TYPE_OTHER));

    // ==========================================
    // Data-stream error selection
    dstream_if ds();
    assign ds.badVaddr = badVaddrFlag;
    assign ds.dtlbMiss = dtlbMiss;
    assign ds.misalign = misalignFlag;
    assign ds.fault = dataFault;
    assign ds.handlerMode = privilegedHandlerMode;
    dstream_error_select dsel (
        .ds(ds)
    );

    // ==========================================
    // Priority selection
    logic pending;
    logic pickTrap;
    logic [13:0] next_offset;
    always_comb begin
        pending = 1'b1;
        pickTrap = 1'b0;
        next_offset = RESET_OFFSET;
        if (machineCheck) begin
            next_offset = MACHINE_CHECK_ENTRY_OFFSET;
        end else if (arithTrap) begin
            next_offset = ARITHMETIC_TRAP_ENTRY_OFFSET;
        end else if (interruptReq && !privilegedHandlerMode) begin
            next_offset = INTR_OFFSET;
        end else if (ds.hit) begin
            next_offset = ds.offset;
        end else if (itlbMiss) begin
            next_offset = ITLB_OFFSET;
        end else if (ifetchViolation) begin
            next_offset = IVIOL_OFFSET;
        end else if (softwareTrapInstr && !trapIllegal) begin
            pickTrap = 1'b1;
            next_offset = privTrap ? trapOffset(PRIV_TRAP_BASE, trapFunction)
                : trapOffset(USER_TRAP_BASE, trapFunction);
        end else if (illegalHit) begin
            next_offset = ILLEGAL_OFFSET;
        end else if (anyFpTrap) begin
            next_offset = FPDIS_OFFSET;
        end else begin
            pending = 1'b0;
        end
    end

    // ==========================================
    // Dispatch sequence
    typedef enum logic [1:0] {IDLE, DRAIN, REDIRECT} seq_t;
    seq_t state;
    logic [33:0] next_return;
    logic dispatchNow;
    assign dispatchNow = (state == DRAIN) && pending && pipeDrained;
    assign next_return = pickTrap ? faultPc + RETURN_STEP : faultPc;
    assign drainRequest = (state == DRAIN);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= REDIRECT;
        end else begin
            case (state)
                IDLE: begin
                    if (pending) begin
                        state <= DRAIN;
                    end
                end
                DRAIN: begin
                    if (!pending) begin
                        state <= IDLE;
                    end else if (pipeDrained) begin
                        state <= REDIRECT;
                    end
                end
                REDIRECT: state <= IDLE;
                default: state <= IDLE;
            endcase
        end
    end

    // Entry offset and return address capture
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            entryOffset <= RESET_OFFSET;
        end else if (dispatchNow) begin
            entryOffset <= next_offset;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            exceptionReturnAddress <= BASE_RESET;
        end else if (dispatchNow) begin
            exceptionReturnAddress <= next_return;
        end else if (returnAddrWrite) begin
            exceptionReturnAddress <= returnAddrWriteData;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            handlerBaseAddress <= BASE_RESET;
        end else if (baseWrite) begin
            handlerBaseAddress <= baseWriteData;
        end
    end

    // Mode flag and fetch redirect
    logic returnTaken;
    assign returnTaken = handlerReturnInstr && privilegedHandlerMode
        && state == IDLE && !pending;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            privilegedHandlerMode <= 1'b1;
        end else if (dispatchNow) begin
            privilegedHandlerMode <= 1'b1;
        end else if (returnTaken) begin
            privilegedHandlerMode <= exceptionReturnAddress[0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fetchRedirect <= 1'b0;
            newPc <= BASE_RESET;
        end else begin
            fetchRedirect <= dispatchNow || returnTaken || state == REDIRECT
                && entryOffset == RESET_OFFSET && newPc == BASE_RESET
                && !fetchRedirect && privilegedHandlerMode;
            if (dispatchNow) begin
                newPc <= {handlerBaseAddress[PC_WIDTH-1:BASE_LSB],
                    next_offset};
            end else if (returnTaken) begin
                newPc <= exceptionReturnAddress;
            end
        end
    end

    assign interruptEnable = !privilegedHandlerMode;
    assign imapEnable = !privilegedHandlerMode;
    assign dmapEnable = 1'b1;

    // ==========================================
    // Checks
    sequence drainDone_s;
        state == DRAIN && pending && pipeDrained;
    endsequence
    sequence redirectOut_s;
        ##1 fetchRedirect && privilegedHandlerMode;
    endsequence

    seq_order_a: assert property (@(posedge core_clk) disable iff (reset)
        drainDone_s |-> redirectOut_s)
        else $error("Redirect did not follow drain");
    pc_form_a: assert property (@(posedge core_clk) disable iff (reset)
        dispatchNow |=> newPc[33:14] == $past(handlerBaseAddress[33:14])
        && newPc[13:0] == entryOffset)
        else $error("New PC malformed");
    trap_ret_a: assert property (@(posedge core_clk) disable iff (reset)
        dispatchNow && pickTrap |=>
        exceptionReturnAddress == $past(faultPc) + RETURN_STEP)
        else $error("Trap return address wrong");
    bad_code_a: assert property (@(posedge core_clk) disable iff (reset)
        dispatchNow && softwareTrapInstr && trapFunction[6] && !machineCheck
        && !arithTrap && !interruptReq && !ds.hit && !itlbMiss
        && !ifetchViolation |=> entryOffset == ILLEGAL_OFFSET)
        else $error("Unsupported trap code not illegal");
    priv_mode_a: assert property (@(posedge core_clk) disable iff (reset)
        pickTrap && privTrap |-> currentModeField == KERNEL_MODE)
        else $error("Privileged trap outside kernel");
    machine_check_entry_first_a: assert property (@(posedge core_clk) disable iff (reset)
        dispatchNow && machineCheck |=> entryOffset == MACHINE_CHECK_ENTRY_OFFSET)
        else $error("Machine check not highest");
    trap_off_a: assert property (@(posedge core_clk) disable iff (reset)
        dispatchNow && pickTrap |=> entryOffset[5:0] == 6'h00
        && entryOffset[11:6] == $past(trapFunction[5:0]))
        else $error("Trap region wrong");
    fp_dis_a: assert property (@(posedge core_clk) disable iff (reset)
        pending && next_offset == FPDIS_OFFSET |-> anyFpTrap)
        else $error("FP entry without cause");
    hmode_irq_a: assert property (@(posedge core_clk) disable iff (reset)
        privilegedHandlerMode |-> !interruptEnable && !imapEnable)
        else $error("Handler mode mapping or irq on");
    ret_mode_a: assert property (@(posedge core_clk) disable iff (reset)
        returnTaken |=> privilegedHandlerMode
        == $past(exceptionReturnAddress[0]) && fetchRedirect)
        else $error("Return mode flag wrong");
endmodule

// ### pipe_model.sv
// Purpose: Pipeline partner that reports a drained pipe after a latency
// Assumes: drainRequest stays high until the redirect
// Notes: Latency zero answers in the same cycle as the request
`timescale 1ns/1ps
module pipe_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic drainRequest,
    input wire logic [3:0] latency,
    output logic pipeDrained
);
    logic [3:0] count;
    // ==========
    // Drain cycle count-up
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count <= 4'h0;
        end else if (!drainRequest) begin
            count <= 4'h0;
        end else if (count != 4'hf) begin
            count <= count + 4'h1;
        end
    end
    assign pipeDrained = drainRequest && (count >= latency);
endmodule

// ### testbench.sv
// Purpose: Self-checking bench for the handler dispatch block
// Assumes: Inputs change at the falling edge
// Notes: Faulting address is even so returns leave handler mode
`timescale 1ns/1ps
module testbench
    import dispatch_pkg::*;
;
    logic core_clk, reset, badVaddrFlag, dtlbMiss, misalignFlag;
    logic handlerOnlyInstr, fpIeee, fpEnableBit, handlerReturnInstr;
    logic baseWrite, returnAddrWrite, pipeDrained;
    logic drainRequest, fetchRedirect, privilegedHandlerMode;
    logic interruptEnable, imapEnable, dmapEnable;
    logic [8:0] req;
    logic [7:0] trapFunction;
    logic [1:0] fpRound, fpDatatype, currentModeField;
    logic [3:0] latency;
    logic [13:0] entryOffset;
    logic [33:0] faultPc, baseWriteData, returnAddrWriteData, baseVal;
    logic [33:0] newPc, exceptionReturnAddress, handlerBaseAddress;
    int errCount, numChecks, cycles;
    // ==========
    // Design and partner
    privileged_handler_dispatch dut (.core_clk(core_clk), .reset(reset),
        .machineCheck(req[8]), .arithTrap(req[7]), .interruptReq(req[6]),
        .badVaddrFlag(badVaddrFlag), .dtlbMiss(dtlbMiss),
        .misalignFlag(misalignFlag), .dataFault(req[5]),
        .itlbMiss(req[4]), .ifetchViolation(req[3]),
        .softwareTrapInstr(req[2]), .trapFunction(trapFunction),
        .reservedOpcode(req[1]), .handlerOnlyInstr(handlerOnlyInstr),
        .fpOperation(req[0]), .fpIeee(fpIeee), .fpRound(fpRound),
        .fpDatatype(fpDatatype), .fpEnableBit(fpEnableBit),
        .currentModeField(currentModeField), .faultPc(faultPc),
        .pipeDrained(pipeDrained), .handlerReturnInstr(handlerReturnInstr),
        .baseWrite(baseWrite), .baseWriteData(baseWriteData),
        .returnAddrWrite(returnAddrWrite),
        .returnAddrWriteData(returnAddrWriteData),
        .drainRequest(drainRequest), .fetchRedirect(fetchRedirect),
        .newPc(newPc), .entryOffset(entryOffset),
        .exceptionReturnAddress(exceptionReturnAddress),
        .handlerBaseAddress(handlerBaseAddress),
        .privilegedHandlerMode(privilegedHandlerMode),
        .interruptEnable(interruptEnable), .imapEnable(imapEnable),
        .dmapEnable(dmapEnable));
    pipe_model pipe (.core_clk(core_clk), .reset(reset),
        .drainRequest(drainRequest), .latency(latency),
        .pipeDrained(pipeDrained));
    // ==========
    // Clock and timeout
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            errCount++;
            finish_test;
        end
    end
    // ==========
    // Shared tasks
    task automatic chk(input string what, input logic [33:0] seen, exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic quiet(input logic [8:0] r);
        req = r;
        repeat (8) begin
            @(negedge core_clk);
            chk("noRedirect", {33'h0, fetchRedirect}, 34'h0);
        end
        req = '0;
        handlerOnlyInstr = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic dispatch(input logic [8:0] r, input logic [13:0] off,
        input logic trap);
        int n;
        n = 0;
        req = r;
        while (fetchRedirect !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk("redirect", {33'h0, fetchRedirect}, 34'h1);
        chk("offset", {20'h0, entryOffset}, {20'h0, off});
        chk("newPc", newPc, {baseVal[33:14], off});
        chk("retAddr", exceptionReturnAddress,
            trap ? faultPc + 34'h4 : faultPc);
        chk("mode", {33'h0, privilegedHandlerMode}, 34'h1);
        req = '0;
        {badVaddrFlag, dtlbMiss, misalignFlag, handlerOnlyInstr} = 4'h0;
        @(negedge core_clk);
    endtask
    task automatic ret(input logic [33:0] ra);
        int n;
        n = 0;
        handlerReturnInstr = 1'b1;
        @(negedge core_clk);
        while (fetchRedirect !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        handlerReturnInstr = 1'b0;
        chk("retPc", newPc, ra);
        chk("retMode", {33'h0, privilegedHandlerMode}, {33'h0, ra[0]});
        chk("intEn", {33'h0, interruptEnable}, {33'h0, !ra[0]});
        chk("imap", {33'h0, imapEnable}, {33'h0, !ra[0]});
        @(negedge core_clk);
    endtask
    function automatic logic [13:0] trapOff(input logic [7:0] c,
        input logic [1:0] m);
        if (c <= 8'h3f && m == 2'h0) return 14'h2000 + {c[5:0], 6'h0};
        if (c >= 8'h80 && c <= 8'hbf) return 14'h3000 + {c[5:0], 6'h0};
        return 14'h13e0;
    endfunction
    // ==========
    // Scenarios
    task automatic resetEntry;
        int n;
        n = 0;
        while (fetchRedirect !== 1'b1 && n < 5) begin
            @(negedge core_clk);
            n++;
        end
        chk("resetPc", newPc, 34'h0);
        chk("base", handlerBaseAddress, 34'h0);
        chk("mode", {33'h0, privilegedHandlerMode}, 34'h1);
        chk("imap", {33'h0, imapEnable}, 34'h0);
        chk("dmap", {33'h0, dmapEnable}, 34'h1);
        @(negedge core_clk);
    endtask
    task automatic baseAndReturn;
        baseVal = 34'h2_abcd_4567;
        baseWrite = 1'b1;
        baseWriteData = baseVal;
        @(negedge core_clk);
        baseWrite = 1'b0;
        chk("base", handlerBaseAddress, baseVal);
        returnAddrWriteData = faultPc + 34'h1;
        returnAddrWrite = 1'b1;
        @(negedge core_clk);
        returnAddrWrite = 1'b0;
        ret(faultPc + 34'h1);
        returnAddrWriteData = faultPc;
        returnAddrWrite = 1'b1;
        @(negedge core_clk);
        returnAddrWrite = 1'b0;
        ret(faultPc);
    endtask
    task automatic priorityOrder;
        logic [13:0] offs [9] = '{14'h17e0, 14'h13e0, 14'h2140, 14'h07e0,
            14'h03e0, 14'h01e0, 14'h00e0, 14'h0060, 14'h0020};
        trapFunction = 8'h05;
        for (int i = 8; i >= 0; i--) begin
            latency = i[3:0];
            dispatch(9'h1ff >> (8 - i), offs[i], i == 2);
            ret(i == 2 ? faultPc + 34'h4 : faultPc);
        end
        dispatch(9'h001, 14'h17e0, 1'b0);
        quiet(9'h040);
        ret(faultPc);
        handlerOnlyInstr = 1'b1;
        dispatch(9'h000, 14'h13e0, 1'b0);
        handlerOnlyInstr = 1'b1;
        quiet(9'h000);
        ret(faultPc);
    endtask
    task automatic trapCodes;
        logic [7:0] codes [8] = '{8'h00, 8'h3f, 8'h40, 8'h7f, 8'h80, 8'hbf,
            8'hc0, 8'hff};
        logic [13:0] off;
        for (int k = 0; k < 16; k++) begin
            currentModeField = k[3] ? 2'h3 : 2'h0;
            trapFunction = codes[k[2:0]];
            off = trapOff(trapFunction, currentModeField);
            dispatch(9'h004, off, off != 14'h13e0);
            ret(off != 14'h13e0 ? faultPc + 34'h4 : faultPc);
        end
        currentModeField = 2'h0;
    endtask
    task automatic dataErrors;
        logic [4:0] rows [7] = '{5'h1e, 5'h1a, 5'h10, 5'h0f, 5'h0e, 5'h06,
            5'h02};
        logic [13:0] offs [7] = '{14'h11e0, 14'h01e0, 14'h01e0, 14'h08e0,
            14'h09e0, 14'h11e0, 14'h01e0};
        for (int j = 0; j < 7; j++) begin
            {badVaddrFlag, dtlbMiss, misalignFlag} = rows[j][4:2];
            dispatch({3'h0, rows[j][1], 5'h0}, offs[j], 1'b0);
            if (!rows[j][0]) ret(faultPc);
        end
    endtask
    task automatic fpChecks;
        logic trap;
        fpEnableBit = 1'b1;
        fpIeee = 1'b1;
        for (int k = 0; k < 8; k++) begin
            fpRound = k < 4 ? k[1:0] : FP_ROUND_NORMAL;
            fpDatatype = k < 4 ? FP_TYPE_S : k[1:0];
            trap = (fpRound == FP_ROUND_MINUS_INF) ||
                (fpRound == FP_ROUND_PLUS_INF) || (fpDatatype == FP_TYPE_OTHER);
            if (trap) begin
                dispatch(9'h001, 14'h17e0, 1'b0);
                ret(faultPc);
            end else begin
                quiet(9'h001);
            end
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        req = '0;
        {badVaddrFlag, dtlbMiss, misalignFlag, handlerOnlyInstr} = 4'h0;
        {fpIeee, fpEnableBit, handlerReturnInstr} = 3'h0;
        {baseWrite, returnAddrWrite} = 2'h0;
        trapFunction = 8'h00;
        {fpRound, fpDatatype, currentModeField} = 6'h0;
        latency = 4'h2;
        faultPc = 34'h1_0000_1230;
        baseWriteData = 34'h0;
        returnAddrWriteData = 34'h0;
        baseVal = 34'h0;
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        resetEntry();
        baseAndReturn();
        priorityOrder();
        trapCodes();
        dataErrors();
        fpChecks();
        finish_test;
    end
endmodule
